// ===== verilog/adcr_pkg.sv
// Constants and types shared by the converter register bank
package adcr_pkg;

  localparam int ADCR_NBYTES = 44;
  localparam int ADCR_WADDR_W = 4;

  // Byte offsets of the register map
  localparam logic [5:0] OFF_CTRL_A = 6'h00;
  localparam logic [5:0] OFF_REF = 6'h01;
  localparam logic [5:0] OFF_AVG = 6'h02;
  localparam logic [5:0] OFF_SAMP = 6'h03;
  localparam logic [5:0] OFF_CTRL_B = 6'h04;
  localparam logic [5:0] OFF_WIN = 6'h08;
  localparam logic [5:0] OFF_SOFTWARE_TRIGGER = 6'h0c;
  localparam logic [5:0] OFF_INPUT = 6'h10;
  localparam logic [5:0] OFF_EVENT_CONTROL = 6'h14;
  localparam logic [5:0] OFF_IEN_CLR = 6'h16;
  localparam logic [5:0] OFF_IEN_SET = 6'h17;
  localparam logic [5:0] OFF_IFLAGS = 6'h18;
  localparam logic [5:0] OFF_STATUS = 6'h19;
  localparam logic [5:0] OFF_RESULT = 6'h1a;
  localparam logic [5:0] OFF_WIN_LO = 6'h1c;
  localparam logic [5:0] OFF_WIN_HI = 6'h20;
  localparam logic [5:0] OFF_GAIN = 6'h24;
  localparam logic [5:0] OFF_OFFS = 6'h26;
  localparam logic [5:0] OFF_CALIBRATION = 6'h28;
  localparam logic [5:0] OFF_DEBUG = 6'h2a;

  // Field positions
  localparam int CA_SOFT_RESET = 0;
  localparam int CA_ENABLE = 1;
  localparam int CA_KEEP_RUNNING = 2;
  localparam int IRQ_RESULT_READY = 0;
  localparam int IRQ_OVERRUN = 1;
  localparam int IRQ_WINDOW_MATCH = 2;
  localparam int IRQ_CROSSING_DONE = 3;
  localparam int ST_CROSSING_PENDING = 7;

  localparam logic [7:0] ADCR_RESET_BYTE = 8'h00;

  // Converter clock is modelled as an enable every CONV_DIV bus cycles
  localparam int CONV_DIV = 4;
  localparam int SYNC_TICKS = 2;
  localparam logic [3:0] CONV_DIV_LAST = 4'(CONV_DIV - 1);
  localparam logic [1:0] SYNC_TICKS_LAST = 2'(SYNC_TICKS - 1);

  typedef logic [ADCR_NBYTES-1:0][7:0] adcr_bytes_t;

  // Events from the converter core
  typedef struct packed {
    logic resultValid;
    logic [15:0] result;
    logic overrun;
    logic windowMatch;
  } adcr_conv_ev_t;

  // Configuration seen by the converter core
  typedef struct packed {
    logic enable;
    logic keepRunningAsleep;
    logic [15:0] controlB;
    logic [2:0] windowMode;
    logic [31:0] inputSelect;
    logic [15:0] windowLower;
    logic [15:0] windowUpper;
    logic startPulse;
    logic flushPulse;
  } adcr_cfg_t;

  typedef struct packed {
    adcr_bytes_t mem;
    adcr_cfg_t cfg;
    logic pending;
    logic softResetPending;
    logic [3:0] divCnt;
    logic [1:0] tickCnt;
    logic [31:0] rdData;
    logic [2:0] guardSync;
    logic guard;
  } adcr_state_t;

endpackage

// ===== verilog/adcr_register_bank.sv
// Register bank of the converter peripheral with converter-side crossing
// Operation
// - Registers of 8, 16 and 32 bits take whole-register accesses of any of those sizes at once.
// - Each byte lane or half of a word is written alone, leaving the other lanes untouched.
// - Write-protected registers ignore writes while the access guard is asserted; reads go on.
// - Enable-protected registers take writes only while the enable bit of control_a reads zero.
// - Synchronised registers pass the crossing into the converter domain before taking effect.
// - Bits 7 to 3 of control_a read as zero and software writes zeros there.
// - control_a resets to zero; bit 0 soft reset, bit 1 enable, bit 2 keep running asleep.
// - Interrupt enable clear, enable set and flags share one layout of four event bits.
// - Soft reset returns all registers but debug_control to reset and discards the rest.
// - A written enable reads back at once while crossing_pending stays set until it acts.
module adcr_register_bank (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register port
  input wire logic [adcr_pkg::ADCR_WADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic [3:0] regBe,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Access guard from the protection controller
  input wire logic accessGuard,
  // Converter core
  input wire adcr_pkg::adcr_conv_ev_t convEv,
  output adcr_pkg::adcr_cfg_t cfg,
  output adcr_pkg::adcr_bytes_t regImage,
  // Interrupt
  output logic irq
);
  import adcr_pkg::*;

  adcr_state_t s;
  adcr_state_t next_s;

  // Writable bits of each byte; reserved bytes and bits stay zero
  function automatic logic [7:0] byteMask(input logic [5:0] o);
    case (o)
      OFF_CTRL_A: byteMask = 8'h07;
      OFF_REF: byteMask = 8'h8f;
      OFF_AVG: byteMask = 8'h7f;
      OFF_SAMP: byteMask = 8'h3f;
      OFF_CTRL_B: byteMask = 8'h3f;
      OFF_CTRL_B + 6'h01: byteMask = 8'h07;
      OFF_WIN: byteMask = 8'h07;
      OFF_SOFTWARE_TRIGGER: byteMask = 8'h03;
      OFF_INPUT: byteMask = 8'h1f;
      OFF_INPUT + 6'h01: byteMask = 8'h1f;
      OFF_INPUT + 6'h02: byteMask = 8'hff;
      OFF_INPUT + 6'h03: byteMask = 8'h0f;
      OFF_EVENT_CONTROL: byteMask = 8'h33;
      OFF_WIN_LO, OFF_WIN_LO + 6'h01: byteMask = 8'hff;
      OFF_WIN_HI, OFF_WIN_HI + 6'h01: byteMask = 8'hff;
      OFF_GAIN, OFF_OFFS: byteMask = 8'hff;
      OFF_GAIN + 6'h01, OFF_OFFS + 6'h01: byteMask = 8'h0f;
      OFF_CALIBRATION: byteMask = 8'hff;
      OFF_CALIBRATION + 6'h01: byteMask = 8'h07;
      OFF_DEBUG: byteMask = 8'h01;
      default: byteMask = 8'h00;
    endcase
  endfunction

  // Interrupt, status and result bytes are outside the guard
  function automatic logic isWriteProt(input logic [5:0] o);
    isWriteProt = !(o >= OFF_IEN_CLR && o <= OFF_RESULT + 6'h01);
  endfunction

  function automatic logic isEnableProt(input logic [5:0] o);
    isEnableProt = (o == OFF_REF) || (o == OFF_AVG) || (o == OFF_SAMP)
      || (o == OFF_CTRL_B) || (o == OFF_CTRL_B + 6'h01);
  endfunction

  function automatic logic isWriteSync(input logic [5:0] o);
    isWriteSync = (o == OFF_CTRL_A) || (o == OFF_CTRL_B) || (o == OFF_CTRL_B + 6'h01)
      || (o == OFF_WIN) || (o == OFF_SOFTWARE_TRIGGER)
      || (o >= OFF_INPUT && o <= OFF_INPUT + 6'h03)
      || (o == OFF_WIN_LO) || (o == OFF_WIN_LO + 6'h01)
      || (o == OFF_WIN_HI) || (o == OFF_WIN_HI + 6'h01);
  endfunction

  function automatic logic [7:0] readByte(input adcr_state_t st, input logic [5:0] o);
    if (o >= 6'(ADCR_NBYTES)) begin
      readByte = 8'h00;
    end else if (o == OFF_IEN_CLR) begin
      readByte = st.mem[OFF_IEN_SET];
    end else if (o == OFF_STATUS) begin
      readByte = {st.pending, 7'h00};
    end else begin
      readByte = st.mem[o];
    end
  endfunction

  always_comb begin
    logic [5:0] o;
    logic [7:0] d;
    logic softResetHit;
    logic convTick;
    logic done;
    logic [7:0] setEv;
    o = 6'h00;
    d = 8'h00;
    next_s = s;
    next_s.cfg.startPulse = 1'b0;
    next_s.cfg.flushPulse = 1'b0;

    // Three-stage guard input; a change counts once stages two and three agree
    next_s.guardSync = {s.guardSync[1:0], accessGuard};
    if (s.guardSync[2] == s.guardSync[1]) begin
      next_s.guard = s.guardSync[2];
    end

    // Read data stands only in the cycle after the strobe
    next_s.rdData = 32'h0;
    if (regRd) begin
      for (int k = 0; k < 4; k++) begin
        next_s.rdData[8*k +: 8] = readByte(s, {regAddr, 2'(k)});
      end
    end

    // A soft reset write wins over every other byte of the same access
    softResetHit = regWr && regBe[0] && regAddr == OFF_CTRL_A[5:2]
      && regWdata[CA_SOFT_RESET] && !s.guard && !s.pending;

    if (softResetHit) begin
      next_s.pending = 1'b1;
      next_s.softResetPending = 1'b1;
      next_s.mem[OFF_CTRL_A][CA_SOFT_RESET] = 1'b1;
    end else if (regWr) begin
      for (int k = 0; k < 4; k++) begin
        o = {regAddr, 2'(k)};
        d = regWdata[8*k +: 8];
        if (regBe[k] && o < 6'(ADCR_NBYTES)) begin
          if (isWriteProt(o) && s.guard) begin
            // Discarded under the guard
          end else if (isEnableProt(o) && s.mem[OFF_CTRL_A][CA_ENABLE]) begin
            // Discarded while enabled
          end else if (isWriteSync(o) && s.pending) begin
            // Crossing busy: later write is dropped rather than stalling the port
          end else if (o == OFF_IEN_CLR) begin
            next_s.mem[OFF_IEN_SET] = next_s.mem[OFF_IEN_SET] & ~(d & 8'h0f);
          end else if (o == OFF_IEN_SET) begin
            next_s.mem[OFF_IEN_SET] = next_s.mem[OFF_IEN_SET] | (d & 8'h0f);
          end else if (o == OFF_IFLAGS) begin
            next_s.mem[OFF_IFLAGS] = s.mem[OFF_IFLAGS] & ~(d & 8'h0f);
          end else begin
            next_s.mem[o] = d & byteMask(o);
            if (isWriteSync(o)) begin
              next_s.pending = 1'b1;
            end
          end
        end
      end
    end

    // Converter clock enable and crossing completion
    convTick = s.divCnt == CONV_DIV_LAST;
    done = s.pending && convTick && s.tickCnt == SYNC_TICKS_LAST;
    if (s.pending) begin
      next_s.divCnt = convTick ? 4'h0 : s.divCnt + 4'h1;
      if (convTick) begin
        next_s.tickCnt = s.tickCnt + 2'h1;
      end
    end else begin
      next_s.divCnt = 4'h0;
      next_s.tickCnt = 2'h0;
    end

    // Hardware events; a set in the same cycle as a clear wins
    setEv = 8'h00;
    if (s.cfg.enable) begin
      setEv[IRQ_RESULT_READY] = convEv.resultValid;
      setEv[IRQ_OVERRUN] = convEv.overrun;
      setEv[IRQ_WINDOW_MATCH] = convEv.windowMatch;
      if (convEv.resultValid) begin
        next_s.mem[OFF_RESULT] = convEv.result[7:0];
        next_s.mem[OFF_RESULT + 6'h01] = convEv.result[15:8];
      end
    end

    if (done) begin
      next_s.pending = 1'b0;
      next_s.divCnt = 4'h0;
      next_s.tickCnt = 2'h0;
      if (s.softResetPending) begin
        for (int b = 0; b < ADCR_NBYTES; b++) begin
          if (6'(b) != OFF_DEBUG) begin
            next_s.mem[b] = ADCR_RESET_BYTE;
          end
        end
        next_s.softResetPending = 1'b0;
        next_s.cfg = '0;
        setEv = 8'h00;
      end else begin
        // Bus-side values take effect in the converter domain only now
        next_s.cfg.enable = s.mem[OFF_CTRL_A][CA_ENABLE];
        next_s.cfg.keepRunningAsleep = s.mem[OFF_CTRL_A][CA_KEEP_RUNNING];
        next_s.cfg.controlB = {s.mem[OFF_CTRL_B + 6'h01], s.mem[OFF_CTRL_B]};
        next_s.cfg.windowMode = s.mem[OFF_WIN][2:0];
        next_s.cfg.inputSelect = {s.mem[OFF_INPUT + 6'h03], s.mem[OFF_INPUT + 6'h02],
                                  s.mem[OFF_INPUT + 6'h01], s.mem[OFF_INPUT]};
        next_s.cfg.windowLower = {s.mem[OFF_WIN_LO + 6'h01], s.mem[OFF_WIN_LO]};
        next_s.cfg.windowUpper = {s.mem[OFF_WIN_HI + 6'h01], s.mem[OFF_WIN_HI]};
        next_s.cfg.startPulse = s.mem[OFF_SOFTWARE_TRIGGER][1];
        next_s.cfg.flushPulse = s.mem[OFF_SOFTWARE_TRIGGER][0];
        // Trigger bits are commands, so they drop once delivered
        next_s.mem[OFF_SOFTWARE_TRIGGER] = 8'h00;
        setEv[IRQ_CROSSING_DONE] = 1'b1;
      end
    end
    next_s.mem[OFF_IFLAGS] = next_s.mem[OFF_IFLAGS] | setEv;
    // The image must show what a read returns, so mirror the derived bytes
    next_s.mem[OFF_IEN_CLR] = next_s.mem[OFF_IEN_SET];
    next_s.mem[OFF_STATUS] = {next_s.pending, 7'h00};
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign regRdata = s.rdData;
  assign cfg = s.cfg;
  assign regImage = s.mem;
  assign irq = |(s.mem[OFF_IFLAGS] & s.mem[OFF_IEN_SET]);

endmodule // adcr_register_bank

// ===== tb/adcr_bank_assertions.sv
// Port checker bound to the converter register bank
module adcr_bank_assertions (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register port
  input wire logic [adcr_pkg::ADCR_WADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic [3:0] regBe,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  // Guard, converter and interrupt
  input wire logic accessGuard,
  input wire adcr_pkg::adcr_conv_ev_t convEv,
  input wire adcr_pkg::adcr_cfg_t cfg,
  input wire adcr_pkg::adcr_bytes_t regImage,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import adcr_pkg::*;
  // Guard age: the bank only sees a guard change after its synchroniser
  logic [2:0] gAge;
  logic gPrev;
  logic pend;
  logic settled;
  assign pend = regImage[OFF_STATUS][ST_CROSSING_PENDING];
  assign settled = gAge > 3'h3;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gAge <= 3'h0;
      gPrev <= 1'b0;
    end else begin
      gPrev <= accessGuard;
      gAge <= (accessGuard != gPrev) ? 3'h0 : gAge + 3'(gAge != 3'h7);
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  AST_RD_WORD: assert property (regRd && regAddr < 4'hb |=>
    regRdata == $past(regImage[{regAddr, 2'h0} +: 4])) else $error("read word wrong");
  AST_IRQ: assert property (
    irq == |(regImage[OFF_IFLAGS][3:0] & regImage[OFF_IEN_SET][3:0])) else $error("irq wrong");
  AST_EN_NOW: assert property (regWr && regAddr == 4'h0 && regBe[0] && regWdata[1:0] == 2'h2
    && !pend && !accessGuard && settled |=> regImage[OFF_CTRL_A][CA_ENABLE] && pend)
    else $error("enable not shown at once");
  AST_PEND_END: assert property ($rose(pend) |-> ##[1:12] !pend)
    else $error("crossing never completed");
  AST_CFG_SYNC: assert property ($changed(cfg.enable) |-> $fell(pend))
    else $error("enable moved outside completion");
  AST_EN_PROT: assert property (regWr && regAddr == 4'h0 && regBe[2] && !pend
    && regImage[OFF_CTRL_A][CA_ENABLE] |=> $stable(regImage[OFF_AVG])) else $error("avg written");
  AST_GUARD: assert property (regWr && regAddr == 4'h7 && accessGuard && settled
    |=> $stable(regImage[OFF_WIN_LO])) else $error("guarded write landed");
  AST_FLAG_CLR: assert property (regWr && regAddr == 4'h6 && regBe[0] && regWdata[0]
    && !convEv.resultValid |=> !regImage[OFF_IFLAGS][IRQ_RESULT_READY]) else $error("flag kept");
endmodule // adcr_bank_assertions
bind adcr_register_bank adcr_bank_assertions adcr_bank_assertions_inst (.core_clk, .rstn,
  .regAddr, .regWdata, .regBe, .regWr, .regRd, .regRdata, .accessGuard, .convEv, .cfg,
  .regImage, .irq);

// ===== tb/adcr_conv_model.sv
// Behavioural converter core that raises result and overrun events
module adcr_conv_model (
  // Clock
  input wire logic core_clk,
  // Events
  output adcr_pkg::adcr_conv_ev_t convEv
);
  timeunit 1ns;
  timeprecision 1ps;
  import adcr_pkg::*;
  initial convEv = '0;
  // Kind bit 0 gives a result, bit 1 an overrun; each lasts one cycle
  task automatic fire(input logic [15:0] res, input logic [1:0] kind);
    @(posedge core_clk);
    convEv <= '{resultValid: kind[0], result: res, overrun: kind[1], windowMatch: 1'b0};
    @(posedge core_clk);
    convEv <= '0;
  endtask
endmodule // adcr_conv_model

// ===== tb/test_adcr_register_bank.sv
// Self-checking bench for the converter register bank
module test_adcr_register_bank;
  timeunit 1ns;
  timeprecision 1ps;
  import adcr_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADCR_WADDR_W-1:0] regAddr = '0;
  logic [31:0] regWdata = '0;
  logic [3:0] regBe = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic accessGuard = 1'b0;
  logic [31:0] regRdata;
  logic irq;
  adcr_conv_ev_t convEv;
  adcr_cfg_t cfg;
  adcr_bytes_t regImage;
  int fails = 0;
  int checksDone = 0;
  int cyc = 0;
  adcr_register_bank adcr_register_bank_inst (.core_clk, .rstn, .regAddr, .regWdata, .regBe,
    .regWr, .regRd, .regRdata, .accessGuard, .convEv, .cfg, .regImage, .irq);
  adcr_conv_model adcr_conv_model_inst (.core_clk, .convEv);
  initial forever #4 core_clk = ~core_clk;
  task automatic summarize();
    $display("checks=%0d fails=%0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fails++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regBe <= be;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 chk(regRdata, exp);
  endtask
  // Bounded wait for the crossing to finish
  task automatic idle();
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < 30 && regImage[OFF_STATUS][7] !== 1'b0; i++) @(posedge core_clk);
    if (regImage[OFF_STATUS][7] !== 1'b0) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, regImage[OFF_STATUS], 8'h00);
    end
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    for (int a = 0; a < 11; a++) rd(4'(a), 32'h0);
    wr(4'h1, 4'hc, 32'hffff_0000);
    rd(4'h1, 32'h0);
    wr(4'h4, 4'h5, 32'h1122_3344);
    idle();
    rd(4'h4, 32'h0022_0004);
    wr(4'h4, 4'hf, 32'h0aaa_1e1e);
    idle();
    rd(4'h4, 32'h0aaa_1e1e);
    wr(4'h7, 4'h3, 32'hffff_1234);
    idle();
    rd(4'h7, 32'h0000_1234);
    wr(4'ha, 4'h4, 32'h0001_0000);
    wr(4'h0, 4'h4, 32'h0005_0000);
    wr(4'h0, 4'h1, 32'h0000_0006);
    rd(4'h6, 32'h0000_8008);
    rd(4'h0, 32'h0005_0006);
    idle();
    chk({31'h0, cfg.enable}, 32'h1);
    wr(4'h0, 4'h4, 32'h0033_0000);
    rd(4'h0, 32'h0005_0006);
    accessGuard <= 1'b1;
    repeat (5) @(posedge core_clk);
    wr(4'h7, 4'h3, 32'h0000_beef);
    rd(4'h7, 32'h0000_1234);
    wr(4'h5, 4'h8, 32'h0100_0000);
    rd(4'h5, 32'h0101_0000);
    accessGuard <= 1'b0;
    repeat (5) @(posedge core_clk);
    adcr_conv_model_inst.fire(16'h0abc, 2'h1);
    #1 chk({31'h0, irq}, 32'h1);
    rd(4'h6, 32'h0abc_0009);
    wr(4'h5, 4'h4, 32'h0001_0000);
    #1 chk({31'h0, irq}, 32'h0);
    adcr_conv_model_inst.fire(16'h0000, 2'h2);
    wr(4'h5, 4'h8, 32'h0200_0000);
    #1 chk({31'h0, irq}, 32'h1);
    wr(4'h6, 4'h1, 32'h0000_000f);
    #1 chk({31'h0, irq}, 32'h0);
    rd(4'h6, 32'h0abc_0000);
    // Soft reset with only bit 0 written: enable and keep running read back until it acts
    wr(4'h0, 4'h1, 32'h0000_0001);
    rd(4'h0, 32'h0005_0007);
    idle();
    rd(4'h0, 32'h0);
    chk({31'h0, cfg.enable}, 32'h0);
    rd(4'h7, 32'h0);
    rd(4'h5, 32'h0);
    rd(4'ha, 32'h0001_0000);
    summarize();
  end
endmodule // test_adcr_register_bank
